// file: spi_port_pkg.sv
/*
  shared constants and types of the serial access port: address map,
  strobe codes, radio state codes, port state record and its reset value.
  assumes nothing of its surroundings.
*/
package spi_port_pkg;
  // address map of the serial space
  localparam logic [5:0] CFG_LAST = 6'h2e;
  localparam logic [5:0] STAT_FIRST = 6'h30;
  localparam logic [5:0] STAT_LAST = 6'h3d;
  localparam logic [5:0] FIFO_ADDR = 6'h3f;
  localparam int CFG_NUM = 47;
  localparam int STAT_NUM = 14;
  localparam int FIFO_DEPTH = 64;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] AVAIL_MAX = 4'hf;
  // strobe codes inside the strobe range (plain defaults)
  localparam logic [5:0] S_CHIP_RESET = 6'h30;
  localparam logic [5:0] S_OSC_OFF = 6'h32;
  localparam logic [5:0] S_GO_IDLE = 6'h36;
  localparam logic [5:0] S_POWER_DOWN = 6'h39;
  localparam logic [5:0] S_FLUSH_RX = 6'h3a;
  // radio state codes as seen in the status byte
  localparam logic [2:0] RS_IDLE = 3'h0;
  localparam logic [2:0] RS_RX_OVERFLOW = 3'h6;

  typedef enum logic [3:0] {
    PH_HDR = 4'b0001,
    PH_WR = 4'b0010,
    PH_RD = 4'b0100,
    PH_SKIP = 4'b1000
  } phase_t;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [2:0] si_sync;
    logic sclk_st;
    logic cs_n_st;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic tx_load;
    logic [7:0] tx_next;
    phase_t ph;
    logic [5:0] acc_addr;
    logic acc_burst;
    logic acc_rw;
    logic [CFG_NUM-1:0][7:0] cfg;
    logic discard;
    logic pend_valid;
    logic [5:0] pend_code;
    logic strobe_p;
    logic [5:0] strobe_code;
    logic pop_p;
    logic flush_p;
    logic sleep_q;
    logic so;
    logic so_oe;
  } port_state_t;

  localparam port_state_t PORT_RST = '{
    cs_sync: 3'h7, cs_n_st: 1'b1, ph: PH_HDR, default: '0};
endpackage : spi_port_pkg

// file: radio_spi_access_port.sv
/*
  serial slave access port of a receiver: configuration registers,
  status register reads, command strobes and receive fifo reads.
  assumes the serial pins come from another clock domain and are
  oversampled by clk; the fifo offers its head byte on fifo_rd_data
  and removes it on fifo_pop; radio_state and fifo_count are on clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each transaction opens with header: read flag, burst flag, six-bit address
// - every byte shifts most significant bit first, both directions
// - chip select rising mid-byte abandons that byte unapplied
// - configuration registers occupy addresses 0x00 to 0x2E
// - configuration registers are written or read as the read flag selects
// - writes return the status byte during header and every data byte
// - reads return status during the header, register contents afterwards
// - burst loads an address counter that advances every eight clocks
// - addresses 0x30 to 0x3D: burst means status read, else strobe
// - status registers are read only, one at a time, never burst
// - a strobe is a lone header with burst clear, starting a sequence
// - after go-idle, other strobes are dropped until the radio is idle
// - strobes act at once, power-down and oscillator-off at chip select rise
// - the receive fifo is read at address 0x3F with read flag set
// - header 0xBF reads one fifo byte, then a new header follows
// - header 0xFF reads fifo bytes until chip select rises
// - fifo flush honoured only in idle or overflow; sleep entry flushes
// - shared output is serial output whenever chip select is low
// - status byte low four bits give bytes available in the fifo, saturating at 15
module radio_spi_access_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic sclk,
  input wire logic chip_select_pin_n,
  input wire logic si,
  output logic shared_status_output,
  output logic shared_status_oe,
  // alternate use of the shared output while deselected
  input wire logic status_out_en,
  input wire logic status_out_val,
  // radio status
  input wire logic chip_rdy_n,
  input wire logic [2:0] radio_state_readback,
  input wire logic radio_sleep,
  input wire logic [spi_port_pkg::STAT_NUM*8-1:0] status_regs,
  // receive fifo
  input wire logic [7:0] fifo_rd_data,
  input wire logic [6:0] rx_byte_count_status,
  output logic fifo_pop,
  output logic fifo_flush,
  // strobes and configuration
  output logic strobe_pulse,
  output logic [5:0] strobe_code,
  output logic [spi_port_pkg::CFG_NUM*8-1:0] cfg_regs
);
  import spi_port_pkg::*;

  port_state_t q;
  port_state_t n;
  logic rst_s1_ff;
  logic rst_ff;

  // derived events on the filtered pins
  wire logic sclk_ok = q.sclk_sync[1] == q.sclk_sync[2];
  wire logic cs_ok = q.cs_sync[1] == q.cs_sync[2];
  wire logic sclk_rise = sclk_ok && q.sclk_sync[2] && !q.sclk_st;
  wire logic sclk_fall = sclk_ok && !q.sclk_sync[2] && q.sclk_st;
  wire logic cs_fall = cs_ok && !q.cs_sync[2] && q.cs_n_st;
  wire logic cs_rise = cs_ok && q.cs_sync[2] && !q.cs_n_st;
  wire logic byte_done = !q.cs_n_st && !cs_rise && sclk_rise && q.bit_cnt == 3'd7;
  wire logic [7:0] rx_byte = {q.rx_sh[6:0], q.si_sync[2]};
  wire logic idle_now = radio_state_readback == RS_IDLE;
  wire logic flush_ok = idle_now || radio_state_readback == RS_RX_OVERFLOW;
  wire logic sleep_rise = radio_sleep && !q.sleep_q;
  wire logic [3:0] avail = (rx_byte_count_status > 7'(AVAIL_MAX)) ? AVAIL_MAX :
                           rx_byte_count_status[3:0];
  wire logic [7:0] status_byte = {chip_rdy_n, radio_state_readback, avail};
  wire logic [5:0] hdr_addr = rx_byte[5:0];
  wire logic [5:0] next_addr = q.acc_addr + 6'd1;

  // read back of a configuration register, zero above address 0x2E
  function automatic logic [7:0] cfg_at(input port_state_t s, input logic [5:0] a);
    cfg_at = (a <= CFG_LAST) ? s.cfg[a] : 8'h00;
  endfunction : cfg_at

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_ff <= rst_s1_ff;
    end
  end

  // next state of the whole port
  always_comb begin
    n = q;
    n.sclk_sync = {q.sclk_sync[1:0], sclk};
    n.cs_sync = {q.cs_sync[1:0], chip_select_pin_n};
    n.si_sync = {q.si_sync[1:0], si};
    n.strobe_p = 1'b0;
    n.pop_p = 1'b0;
    n.flush_p = 1'b0;
    n.sleep_q = radio_sleep;
    if (sclk_ok) begin
      n.sclk_st = q.sclk_sync[2];
    end
    if (cs_ok) begin
      n.cs_n_st = q.cs_sync[2];
    end
    if (sleep_rise) begin
      n.flush_p = 1'b1;
    end
    if (idle_now) begin
      n.discard = 1'b0; // cleared first so a new go-idle below wins
    end
    if (cs_fall) begin
      n.ph = PH_HDR;
      n.bit_cnt = 3'd0;
      n.tx_sh = status_byte;
      n.tx_load = 1'b0;
    end else if (cs_rise) begin
      n.ph = PH_HDR;
      n.bit_cnt = 3'd0;
      n.tx_load = 1'b0;
      if (q.pend_valid) begin
        n.pend_valid = 1'b0;
        if (!q.discard) begin
          n.strobe_p = 1'b1;
          n.strobe_code = q.pend_code;
        end
      end
    end else if (!q.cs_n_st && sclk_rise) begin
      n.rx_sh = rx_byte;
      n.bit_cnt = q.bit_cnt + 3'd1;
      if (byte_done) begin
        n.tx_load = 1'b1;
        n.tx_next = status_byte;
        case (q.ph)
          PH_HDR: begin
            n.acc_rw = rx_byte[7];
            n.acc_burst = rx_byte[6];
            n.acc_addr = hdr_addr;
            if (hdr_addr <= CFG_LAST) begin
              n.ph = rx_byte[7] ? PH_RD : PH_WR;
              if (rx_byte[7]) begin
                n.tx_next = q.cfg[hdr_addr];
              end
            end else if (hdr_addr >= STAT_FIRST && hdr_addr <= STAT_LAST) begin
              if (rx_byte[6]) begin
                n.ph = rx_byte[7] ? PH_RD : PH_SKIP;
                if (rx_byte[7]) begin
                  n.tx_next = status_regs[hdr_addr[3:0]*8 +: 8]; // writes keep the status byte
                end
              end else begin
                n.ph = PH_HDR;
                if (!q.discard || hdr_addr == S_GO_IDLE) begin
                  case (hdr_addr)
                    S_GO_IDLE: begin
                      n.discard = 1'b1;
                      n.strobe_p = 1'b1;
                      n.strobe_code = hdr_addr;
                    end
                    S_POWER_DOWN, S_OSC_OFF: begin
                      n.pend_valid = 1'b1;
                      n.pend_code = hdr_addr;
                    end
                    S_FLUSH_RX: begin
                      n.flush_p = n.flush_p | flush_ok;
                    end
                    default: begin
                      n.strobe_p = 1'b1;
                      n.strobe_code = hdr_addr;
                    end
                  endcase
                end
              end
            end else if (hdr_addr == FIFO_ADDR && rx_byte[7]) begin
              n.ph = PH_RD;
              n.pop_p = 1'b1;
              n.tx_next = fifo_rd_data;
            end else begin
              n.ph = PH_SKIP;
            end
          end
          PH_WR: begin
            if (q.acc_addr <= CFG_LAST) begin
              n.cfg[q.acc_addr] = rx_byte;
            end
            if (q.acc_burst) begin
              n.acc_addr = next_addr;
            end else begin
              n.ph = PH_HDR;
            end
          end
          PH_RD: begin
            if (q.acc_addr == FIFO_ADDR && q.acc_burst) begin
              n.pop_p = 1'b1;
              n.tx_next = fifo_rd_data;
            end else if (q.acc_burst && q.acc_addr < STAT_FIRST) begin
              n.acc_addr = next_addr;
              n.tx_next = cfg_at(q, next_addr);
            end else begin
              n.ph = PH_HDR;
            end
          end
          PH_SKIP: begin
            n.ph = q.acc_burst ? PH_SKIP : PH_HDR;
          end
          default: begin
            n.ph = PH_HDR;
          end
        endcase
      end
    end else if (!q.cs_n_st && sclk_fall) begin
      n.tx_sh = q.tx_load ? q.tx_next : {q.tx_sh[6:0], 1'b0};
      n.tx_load = 1'b0;
    end
    // shared pin: serial output while selected, else status use
    if (!q.cs_n_st) begin
      n.so = n.tx_sh[7];
      n.so_oe = 1'b1;
    end else begin
      n.so = status_out_val;
      n.so_oe = status_out_en;
    end
  end

  // the single state register
  always_ff @(posedge clk or negedge rst_ff) begin
    if (!rst_ff) begin
      q <= PORT_RST;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign shared_status_output = q.so;
  assign shared_status_oe = q.so_oe;
  assign fifo_pop = q.pop_p;
  assign fifo_flush = q.flush_p;
  assign strobe_pulse = q.strobe_p;
  assign strobe_code = q.strobe_code;
  assign cfg_regs = q.cfg;

  // checks beside the logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_ff);

  chk_so_selected: assert property (!q.cs_n_st |=> q.so_oe)
    else $error("shared output not driven while selected");
  chk_strobe_single: assert property (q.strobe_p |-> q.ph == PH_HDR)
    else $error("strobe left the port outside header phase");
  chk_flush_gate: assert property (q.flush_p |-> $past(flush_ok || sleep_rise))
    else $error("fifo flushed in a forbidden state");
  chk_discard_idle: assert property (
    q.strobe_p && q.strobe_code != S_GO_IDLE |-> !$past(q.discard))
    else $error("strobe passed while discarding");
  chk_pd_at_cs: assert property (
    q.strobe_p && (q.strobe_code == S_POWER_DOWN || q.strobe_code == S_OSC_OFF)
    |-> $past(cs_rise))
    else $error("deferred strobe not tied to chip select rise");
  chk_cfg_only_done: assert property (
    $changed(q.cfg) |-> $past(byte_done && q.ph == PH_WR))
    else $error("configuration changed without a whole byte");
  chk_burst_advance: assert property (
    byte_done && q.ph == PH_WR && q.acc_burst |=> q.acc_addr == $past(next_addr))
    else $error("burst counter did not advance");
  chk_pop_byte: assert property (q.pop_p |-> $past(byte_done) && $past(q.ph != PH_WR))
    else $error("fifo pop without a finished byte");
  chk_status_count: assert property (
    cs_fall |=> q.tx_sh[3:0] == $past(avail))
    else $error("status byte count wrong");
  chk_msb_shift: assert property (
    !q.cs_n_st && !cs_rise && !cs_fall && sclk_fall && !q.tx_load
    |=> q.tx_sh == {$past(q.tx_sh[6:0]), 1'b0})
    else $error("serial output not shifted msb first");
  chk_hdr_restart: assert property (cs_fall |=> q.bit_cnt == 3'd0 && q.ph == PH_HDR)
    else $error("frame did not restart at a header byte");
  chk_write_status: assert property (byte_done && q.ph == PH_WR |=> q.tx_next == $past(status_byte))
    else $error("write data slot not answered with status");
  chk_read_cfg: assert property (
    byte_done && q.ph == PH_HDR && rx_byte[7] && hdr_addr <= CFG_LAST |=> q.tx_next == $past(q.cfg[hdr_addr]))
    else $error("register read did not queue its contents");
  chk_so_deselect: assert property (q.cs_n_st |=> q.so_oe == $past(status_out_en))
    else $error("shared output enable wrong while deselected");

  cov_burst_write: cover property (byte_done && q.ph == PH_WR && q.acc_burst);
  cov_fifo_burst: cover property (q.pop_p ##[1:400] q.pop_p);
  cov_strobe: cover property (q.strobe_p && q.strobe_code == S_GO_IDLE);
  cov_abort: cover property (cs_rise && q.bit_cnt != 3'd0);
  cov_status_read: cover property (byte_done && q.ph == PH_HDR && rx_byte[7:6] == 2'b11 &&
    hdr_addr >= STAT_FIRST && hdr_addr <= STAT_LAST);
endmodule : radio_spi_access_port

`default_nettype wire

// file: spi_host_model.sv
/*
  host side serial master model: frames, whole or cut bytes, msb first.
  assumes clk is the bench clock; one link half period is 4 clk (200 ns period).
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // bench clock
  input wire logic clk,
  // serial link
  input wire logic so,
  output logic sclk,
  output logic cs_n,
  output logic si
);
  // link idles deselected with the clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // half a link period; four clk per level give a 200 ns link period
  task automatic half();
    repeat (4) @(negedge clk);
  endtask : half
  // lower chip select, then let the port drive its output
  task automatic sel();
    cs_n = 1'b0;
    half();
    half();
  endtask : sel
  // shift n bits of d msb first, change data while clock low
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = d[i];
      half();
      sclk = 1'b1;
      half();
      q[i] = so;
      sclk = 1'b0;
    end
  endtask : xfer
  // end the frame; released data shows the inverse of its last bit
  task automatic desel();
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
    half();
  endtask : desel
endmodule : spi_host_model
`default_nettype wire

// file: tb_radio_spi_access_port.sv
/*
  self-checking bench of the serial access port: config traffic, status
  reads, strobes, fifo reads. assumes spi_host_model and a fifo model here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_radio_spi_access_port;
  import spi_port_pkg::*;
  logic clk, rst_n, sclk, cs_n, si, so, oe, en, val, rdy_n, sleep, pop, flush, stb;
  logic [2:0] st;
  logic [STAT_NUM*8-1:0] sregs;
  logic [CFG_NUM*8-1:0] cfg;
  logic [7:0] rb, d, mem [64], cfg_m [CFG_NUM];
  logic [6:0] cnt;
  logic [5:0] code, last_code, a, head, h;
  int errors, samples_checked, n_stb, n_fl, b, f;
  logic so_pin;
  radio_spi_access_port u_radio_spi_access_port (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .chip_select_pin_n(cs_n), .si(si), .shared_status_output(so), .shared_status_oe(oe),
    .status_out_en(en), .status_out_val(val), .chip_rdy_n(rdy_n), .radio_state_readback(st),
    .radio_sleep(sleep), .status_regs(sregs), .fifo_rd_data(mem[head]),
    .rx_byte_count_status(cnt), .fifo_pop(pop), .fifo_flush(flush), .strobe_pulse(stb),
    .strobe_code(code), .cfg_regs(cfg));
  // an undriven shared pin shows the inverse of so, which then follows val
  assign so_pin = oe ? so : ~so;
  spi_host_model u_spi_host_model (.clk(clk), .so(so_pin), .sclk(sclk), .cs_n(cs_n), .si(si));
  // bench clock, 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // fifo model and pulse counters
  always @(posedge clk) begin
    if (stb) begin
      n_stb <= n_stb + 1;
      last_code <= code;
    end
    if (flush) cnt <= 7'h00;
    else if (pop) begin
      head <= head + 6'h01;
      cnt <= cnt - 7'h01;
    end
    if (flush) n_fl <= n_fl + 1;
  end
  // hang guard
  initial begin
    #(1_000_000);
    errors++;
    end_sim();
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_st();
    return {rdy_n, st, (cnt > 7'h0f) ? 4'hf : cnt[3:0]};
  endfunction : exp_st
  // header byte; its returned status is checked
  task automatic hdr(input logic [7:0] hb);
    logic [7:0] e;
    e = exp_st();
    u_spi_host_model.xfer(hb, 8, rb);
    chk(rb, e);
  endtask : hdr
  task automatic dat(input logic [7:0] db);
    u_spi_host_model.xfer(db, 8, rb);
  endtask : dat
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    {rst_n, en, val, rdy_n, sleep, head, errors, samples_checked, n_stb, n_fl} = '0;
    st = RS_IDLE;
    cnt = 7'h0e;
    void'($urandom(32'h908ae7a5));
    for (int k = 0; k < STAT_NUM; k++) sregs[8*k +: 8] = 8'($urandom);
    for (int k = 0; k < 64; k++) mem[k] = 8'($urandom);
    for (int k = 0; k < CFG_NUM; k++) cfg_m[k] = CFG_RST;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    for (int k = 0; k < CFG_NUM; k++) chk(cfg[8*k +: 8], CFG_RST);
    chk(oe, 1'b0);
    en = 1'b1;
    val = 1'b1;
    repeat (4) @(negedge clk);
    chk({oe, so}, 2'b11);
    en = 1'b0;
    u_spi_host_model.sel();
    chk(oe, 1'b1);
    for (int n = 0; n < 12; n++) begin
      a = 6'($urandom_range(46));
      d = 8'($urandom);
      hdr({2'b00, a});
      dat(d);
      chk(rb, exp_st());
      cfg_m[a] = d;
      hdr({2'b10, a});
      dat(8'($urandom));
      chk(rb, cfg_m[a]);
    end
    u_spi_host_model.desel();
    for (int k = 0; k < CFG_NUM; k++) chk(cfg[8*k +: 8], cfg_m[k]);
    $display("test single access done");
    rdy_n = 1'b1;
    u_spi_host_model.sel();
    hdr(8'h6c);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      dat(d);
      chk(rb, exp_st());
      if (k < 3) cfg_m[44+k] = d;
    end
    u_spi_host_model.desel();
    u_spi_host_model.sel();
    hdr(8'hec);
    for (int k = 0; k < 4; k++) begin
      dat(8'h00);
      chk(rb, (k < 3) ? cfg_m[44+k] : 8'h00);
    end
    u_spi_host_model.desel();
    rdy_n = 1'b0;
    $display("test burst done");
    b = n_stb;
    u_spi_host_model.sel();
    hdr(8'h05);
    u_spi_host_model.xfer(8'h5a, 5, rb);
    u_spi_host_model.desel();
    u_spi_host_model.sel();
    u_spi_host_model.xfer(8'hb4, 7, rb);
    u_spi_host_model.desel();
    chk(cfg[40 +: 8], cfg_m[5]);
    chk(8'(n_stb - b), 8'h00);
    $display("test abort done");
    for (int k = 0; k < STAT_NUM; k++) begin
      u_spi_host_model.sel();
      hdr({2'b11, 6'(STAT_FIRST + 6'(k))});
      dat(8'h00);
      chk(rb, sregs[8*k +: 8]);
      hdr({2'b11, 6'(STAT_FIRST + 6'(k))});
      dat(8'h00);
      chk(rb, sregs[8*k +: 8]);
      hdr(8'h85);
      dat(8'h00);
      chk(rb, cfg_m[5]);
      u_spi_host_model.desel();
    end
    u_spi_host_model.sel();
    hdr(8'h2f);
    dat(8'h3c);
    chk(rb, exp_st());
    hdr(8'h70);
    for (int k = 0; k < 2; k++) begin
      dat(8'($urandom));
      chk(rb, exp_st());
    end
    u_spi_host_model.desel();
    for (int k = 0; k < CFG_NUM; k++) chk(cfg[8*k +: 8], cfg_m[k]);
    $display("test status done");
    for (int c = 'h30; c <= 'h3d; c++) begin
      b = n_stb;
      f = n_fl;
      u_spi_host_model.sel();
      hdr({2'b10, 6'(c)});
      repeat (8) @(negedge clk);
      chk(8'(n_stb - b), (c == S_FLUSH_RX || c == S_OSC_OFF || c == S_POWER_DOWN) ? 8'h00 : 8'h01);
      u_spi_host_model.desel();
      chk(8'(n_stb - b), (c == S_FLUSH_RX) ? 8'h00 : 8'h01);
      chk(8'(n_fl - f), (c == S_FLUSH_RX) ? 8'h01 : 8'h00);
      if (c != S_FLUSH_RX) chk({2'b00, last_code}, 8'(c));
    end
    $display("test strobes done");
    st = 3'h1;
    b = n_stb;
    f = n_fl;
    u_spi_host_model.sel();
    hdr(8'hb6);
    hdr(8'hb4);
    hdr(8'hba);
    u_spi_host_model.desel();
    chk(8'(n_stb - b), 8'h01);
    chk(8'(n_fl - f), 8'h00);
    st = RS_IDLE;
    repeat (4) @(negedge clk);
    u_spi_host_model.sel();
    hdr(8'hb4);
    u_spi_host_model.desel();
    chk(8'(n_stb - b), 8'h02);
    st = 3'h1;
    u_spi_host_model.sel();
    hdr(8'hba);
    u_spi_host_model.desel();
    chk(8'(n_fl - f), 8'h00);
    st = RS_RX_OVERFLOW;
    u_spi_host_model.sel();
    hdr(8'hba);
    u_spi_host_model.desel();
    sleep = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'(n_fl - f), 8'h02);
    st = RS_IDLE;
    $display("test idle and flush done");
    cnt = 7'h11;
    h = head;
    u_spi_host_model.sel();
    hdr(8'hbf);
    dat(8'h00);
    chk(rb, mem[h]);
    hdr(8'hff);
    for (int k = 1; k < 6; k++) begin
      dat(8'h00);
      chk(rb, mem[6'(h + 6'(k))]);
    end
    u_spi_host_model.desel();
    $display("test fifo done");
    end_sim();
  end
endmodule : tb_radio_spi_access_port
`default_nettype wire
